//--- ews_pkg.sv
/*
  Shared constants, opcodes, state types and reset values for both ends
  of the single-wire write-protect and status link.
  Assumes both ends run on the same 20 MHz clock rate.
*/
// Behaviour
// RULE1: Enable command sets latch, disable command clears it
// RULE2: Single-byte commands need no-acknowledge, else dropped
// RULE3: Latch cleared at power-up and after write commands
// RULE4: Status: bp hi, bp lo, latch, busy; upper zero
// RULE5: Busy reads one during internal write, read-only
// RULE6: Latch flag mirrors latch; other commands keep it
// RULE7: Protect bits only by status write, nonvolatile
// RULE8: Status read accepted at any time, even busy
// RULE9: Status read during status write shows new bits
// RULE10: Live flags; acknowledge repeats status, no-acknowledge ends
// RULE11: Status write needs no-acknowledge after data byte
// RULE12: Protect pair selects none, quarter, half, all
// RULE13: Protected ranges scale with array density
// RULE14: Fill-zero writes 00h everywhere when latch set
// RULE15: Fill-ones writes FFh everywhere when latch set
// RULE16: Fills ignored when any protect bit set
// RULE17: Array and status writes ignored while busy
// RULE18: Power up in shutdown, idle after rising edge
// RULE19: Address pointer undefined until a command loads
// RULE20: Master wakes device: rise, standby, header fall
// RULE21: Latch gates writes; protected blocks never writable
// RULE22: Opcodes for enable, disable and status read
// RULE23: Opcodes for status write and both fills
package ews_pkg;
  localparam int         CLK_NS    = 50;
  localparam int         BIT_NS    = 10000;
  localparam int         BIT_CYC   = BIT_NS / CLK_NS;
  localparam logic [7:0] PH_LAST   = 8'(BIT_CYC - 1);
  localparam logic [7:0] PH_Q1     = 8'(BIT_CYC / 4);
  localparam logic [7:0] PH_HALF   = 8'(BIT_CYC / 2);
  localparam logic [7:0] PH_Q3     = 8'(3 * BIT_CYC / 4);
  localparam int         STBY_US   = 600;
  localparam int         STBY_CYC  = STBY_US * 1000 / CLK_NS;
  localparam int         TWC_US    = 5000;
  localparam int         TWC_CYC   = TWC_US * 1000 / CLK_NS;
  localparam logic [3:0] SLOT_MAK  = 4'h8;
  localparam logic [3:0] SLOT_SAK  = 4'h9;
  localparam int         ARR_AW    = 7;
  // Address byte value is arbitrary
  localparam logic [7:0] DEV_ADDR  = 8'hA0;
  localparam logic [7:0] OP_SET_LATCH = 8'h96; // [RULE22]
  localparam logic [7:0] OP_CLR_LATCH = 8'h91; // [RULE22]
  localparam logic [7:0] OP_RD_STAT   = 8'h05; // [RULE22]
  localparam logic [7:0] OP_WR_STAT   = 8'h6E; // [RULE23]
  localparam logic [7:0] OP_FILL0     = 8'h6D; // [RULE23]
  localparam logic [7:0] OP_FILL1     = 8'h67; // [RULE23]
  localparam logic [7:0] FILL0_VAL    = 8'h00;
  localparam logic [7:0] FILL1_VAL    = 8'hFF;
  localparam int         ST_BP_HI  = 3;
  localparam int         ST_BP_LO  = 2;
  localparam logic [2:0] HR_CMD    = 3'h0;
  localparam logic [2:0] HR_DATA   = 3'h1;
  localparam logic [2:0] HR_CTRL   = 3'h2;
  localparam logic [2:0] HR_STAT   = 3'h3;
  localparam logic [2:0] HR_RXST   = 3'h4;

  // Top two address bits against the protect pair [RULE12] [RULE13]
  function automatic logic ews_prot_hit(input logic [1:0] bp,
                                        input logic [1:0] top);
    return (bp == 2'b11) || (bp == 2'b10 && top[1]) ||
           (bp == 2'b01 && top == 2'b11);
  endfunction

  typedef enum logic [2:0] {
    D_SHUT = 3'b001,
    D_IDLE = 3'b010,
    D_RUN  = 3'b100
  } ews_dst_t;

  typedef struct packed {
    ews_dst_t    st;
    logic        s1;
    logic        s2;
    logic        s3;
    logic [31:0] cnt;
    logic        hdr;
    logic [7:0]  ph;
    logic [3:0]  bit_i;
    logic [1:0]  byte_i;
    logic [7:0]  sh;
    logic [7:0]  cmd;
    logic        smp_a;
    logic        rx;
    logic        rx_ok;
    logic        slave_ack;
    logic        fin;
    logic        dtx;
    logic        latch;
    logic [1:0]  bp;
    logic        bp_ld;
    logic [31:0] twc;
    logic        busy;
    logic        o;
    logic        oe;
    logic        fill;
    logic [7:0]  fill_val;
    logic        wr_ok;
    logic        wr_rej;
    logic [7:0]  status;
  } ews_dev_t;

  // Synchroniser starts at the idle level, so reset is no wake rise
  localparam ews_dev_t DEV_RST = '{st: D_SHUT, s1: 1'b1, s2: 1'b1,
                                   s3: 1'b1, default: '0};

  typedef enum logic [4:0] {
    H_PWR  = 5'b00001,
    H_STBY = 5'b00010,
    H_RDY  = 5'b00100,
    H_HDR  = 5'b01000,
    H_RUN  = 5'b10000
  } ews_hst_t;

  typedef struct packed {
    ews_hst_t    st;
    logic        s1;
    logic        s2;
    logic [31:0] cnt;
    logic [7:0]  ph;
    logic [3:0]  bit_i;
    logic [3:0]  byte_i;
    logic [3:0]  last;
    logic [7:0]  sh;
    logic        smp_a;
    logic        rx;
    logic        rx_ok;
    logic [7:0]  op;
    logic [7:0]  wdat;
    logic [2:0]  polls;
    logic        bad;
    logic        sak_ok;
    logic        done;
    logic [7:0]  rxstat;
    logic [7:0]  rdata;
    logic        o;
    logic        oe;
  } ews_host_t;

  localparam ews_host_t HOST_RST = '{st: H_PWR, default: '0};
endpackage

//--- ews_link_if.sv
/*
  Single-wire link between the bus master and the device.
  Assumes a pull-up: the line is low while any enabled end drives low.
*/
`timescale 1ns/10ps
`default_nettype none
interface ews_link_if;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic line;

  // Low wins on a clash, as on a wired-and line
  assign line = ~((host_oe & ~host_o) | (dev_oe & ~dev_o));

  modport host (output host_o, output host_oe, input line);
  modport dev  (output dev_o, output dev_oe, input line);
endinterface
`default_nettype wire

//--- ews_dev.sv
/*
  Device end: decodes the self-clocked line, runs the latch, status and
  protect commands, and times the internal write cycle.
  Assumes the array owner sits on the user ports and keeps nv_bp_i.
*/
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ews_dev
  import ews_pkg::*;
#(
  parameter int STBY_CYC_P = STBY_CYC,
  parameter int TWC_CYC_P  = TWC_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  ews_link_if.dev                bus,
  input  wire logic [1:0]        nv_bp_i,
  input  wire logic              wr_req_i,
  input  wire logic [ARR_AW-1:0] wr_addr_i,
  output logic                   wr_ok_o,
  output logic                   wr_rej_o,
  output logic                   fill_o,
  output logic [7:0]             fill_val_o,
  output logic [1:0]             nv_bp_o,
  output logic [7:0]             status_o
);
  ews_dev_t   dev_ff;
  ews_dev_t   nxt_dev;
  logic       rise;
  logic       fall;
  logic       master_ack;
  logic       master_noack;
  logic       go_wc;
  logic       txb;
  logic [7:0] stat;

  always_comb begin
    nxt_dev = dev_ff;
    go_wc   = 1'b0;
    rise    = dev_ff.s2 & ~dev_ff.s3;
    fall    = ~dev_ff.s2 & dev_ff.s3;
    master_ack     = dev_ff.rx_ok & dev_ff.rx;
    master_noack   = dev_ff.rx_ok & ~dev_ff.rx;
    stat    = {4'h0, dev_ff.bp, dev_ff.latch, dev_ff.busy}; // [RULE4] [RULE6]
    nxt_dev.s1     = bus.line;
    nxt_dev.s2     = dev_ff.s1;
    nxt_dev.s3     = dev_ff.s2;
    nxt_dev.fill   = 1'b0;
    nxt_dev.wr_ok  = 1'b0;
    nxt_dev.wr_rej = 1'b0;
    // Protect bits come from storage once after reset [RULE7]
    if (!dev_ff.bp_ld) begin
      nxt_dev.bp    = nv_bp_i;
      nxt_dev.bp_ld = 1'b1;
    end
    if (dev_ff.busy) begin
      if (dev_ff.twc == 32'(TWC_CYC_P - 1)) begin
        nxt_dev.busy = 1'b0; // [RULE5]
      end
      nxt_dev.twc = dev_ff.twc + 32'h1;
    end
    // Array writes from the owner: latch, busy and protection gate
    if (wr_req_i) begin
      if (dev_ff.latch && !dev_ff.busy &&
          !ews_prot_hit(dev_ff.bp, wr_addr_i[ARR_AW-1 -: 2])) begin
        nxt_dev.wr_ok = 1'b1; // [RULE21] [RULE17]
        go_wc         = 1'b1;
      end else begin
        nxt_dev.wr_rej = 1'b1; // [RULE21] [RULE17]
      end
    end
    unique case (dev_ff.st)
      D_SHUT: begin
        if (rise) begin
          nxt_dev.st  = D_IDLE; // [RULE18]
          nxt_dev.cnt = '0;
        end
      end
      D_IDLE: begin
        if (!dev_ff.s2) begin
          nxt_dev.cnt = '0;
        end else if (dev_ff.cnt < 32'(STBY_CYC_P)) begin
          nxt_dev.cnt = dev_ff.cnt + 32'h1;
        end
        // Header fall counts only after a full standby
        if (fall && dev_ff.cnt >= 32'(STBY_CYC_P)) begin
          nxt_dev.st     = D_RUN;
          nxt_dev.hdr    = 1'b1;
          nxt_dev.ph     = '0;
          nxt_dev.bit_i  = '0;
          nxt_dev.byte_i = '0;
          nxt_dev.slave_ack    = 1'b0;
          nxt_dev.fin    = 1'b0;
          nxt_dev.dtx    = 1'b0;
        end
      end
      D_RUN: begin
        nxt_dev.ph = dev_ff.ph + 8'h1;
        if (dev_ff.ph == PH_Q1) begin
          nxt_dev.smp_a = dev_ff.s2;
        end
        // Mid-bit rise is a one; no transition is no bit at all
        if (dev_ff.ph == PH_Q3) begin
          nxt_dev.rx    = dev_ff.s2;
          nxt_dev.rx_ok = dev_ff.smp_a ^ dev_ff.s2;
        end
        if (dev_ff.ph == PH_LAST) begin
          nxt_dev.ph = '0;
          if (dev_ff.hdr) begin
            nxt_dev.hdr = 1'b0;
          end else if (dev_ff.bit_i < SLOT_MAK) begin
            nxt_dev.bit_i = dev_ff.bit_i + 4'h1;
            nxt_dev.sh    = {dev_ff.sh[6:0], dev_ff.rx};
          end else if (dev_ff.bit_i == SLOT_MAK) begin
            nxt_dev.bit_i = SLOT_SAK;
            nxt_dev.slave_ack   = 1'b0;
            nxt_dev.fin   = 1'b0;
            unique case (dev_ff.byte_i)
              2'd0: begin
                nxt_dev.slave_ack = master_ack && (dev_ff.sh == DEV_ADDR);
              end
              2'd1: begin
                // Only a received byte loads the command; nothing
                // else is preset [RULE19]
                nxt_dev.cmd = dev_ff.sh;
                if (dev_ff.sh == OP_RD_STAT) begin
                  nxt_dev.slave_ack = dev_ff.rx_ok; // [RULE8]
                  nxt_dev.fin = master_noack;
                end else if (dev_ff.sh == OP_WR_STAT) begin
                  nxt_dev.slave_ack = master_ack;
                end else if (dev_ff.sh == OP_SET_LATCH ||
                             dev_ff.sh == OP_CLR_LATCH ||
                             dev_ff.sh == OP_FILL0 ||
                             dev_ff.sh == OP_FILL1) begin
                  nxt_dev.slave_ack = master_noack; // [RULE2]
                  nxt_dev.fin = 1'b1;
                  if (master_noack) begin
                    if (dev_ff.sh == OP_SET_LATCH) begin
                      nxt_dev.latch = 1'b1; // [RULE1] [RULE6]
                    end else if (dev_ff.sh == OP_CLR_LATCH) begin
                      nxt_dev.latch = 1'b0; // [RULE1] [RULE3]
                    end else if (dev_ff.latch && dev_ff.bp == 2'b00 &&
                                 !dev_ff.busy) begin
                      // [RULE14] [RULE15] [RULE16] [RULE17] [RULE21]
                      nxt_dev.fill     = 1'b1;
                      nxt_dev.fill_val = (dev_ff.sh == OP_FILL1) ?
                                         FILL1_VAL : FILL0_VAL;
                      go_wc            = 1'b1;
                    end
                  end
                end
              end
              default: begin
                if (dev_ff.cmd == OP_RD_STAT) begin
                  nxt_dev.slave_ack = dev_ff.rx_ok; // [RULE10]
                  nxt_dev.fin = master_noack;
                end else begin
                  nxt_dev.slave_ack = master_noack; // [RULE11]
                  nxt_dev.fin = 1'b1;
                  if (master_noack && dev_ff.latch && !dev_ff.busy) begin
                    // New bits show at once, so a poll sees them [RULE9]
                    nxt_dev.bp = dev_ff.sh[ST_BP_HI:ST_BP_LO]; // [RULE7]
                    go_wc      = 1'b1; // [RULE21] [RULE17]
                  end
                end
              end
            endcase
          end else begin
            if (dev_ff.fin || !dev_ff.slave_ack) begin
              nxt_dev.st  = D_IDLE; // [RULE2] [RULE11]
              nxt_dev.cnt = '0;
            end else begin
              nxt_dev.bit_i  = '0;
              nxt_dev.byte_i = (dev_ff.byte_i == 2'd2) ? 2'd2 :
                               dev_ff.byte_i + 2'h1;
              nxt_dev.dtx    = (dev_ff.byte_i != 2'd0) &&
                               (dev_ff.cmd == OP_RD_STAT);
              if (nxt_dev.dtx) begin
                nxt_dev.sh = stat; // [RULE10]
              end
            end
          end
        end
      end
    endcase
    // Any write cycle start drops the latch [RULE3]
    if (go_wc) begin
      nxt_dev.latch = 1'b0;
      nxt_dev.busy  = 1'b1;
      nxt_dev.twc   = '0;
    end
    txb = (nxt_dev.bit_i == SLOT_SAK) ? 1'b1 : nxt_dev.sh[7];
    nxt_dev.oe = (nxt_dev.st == D_RUN) && !nxt_dev.hdr &&
                 ((nxt_dev.dtx && nxt_dev.bit_i < SLOT_MAK) ||
                  (nxt_dev.bit_i == SLOT_SAK && nxt_dev.slave_ack));
    nxt_dev.o  = (nxt_dev.ph < PH_HALF) ? ~txb : txb;
    nxt_dev.status = {4'h0, nxt_dev.bp, nxt_dev.latch, nxt_dev.busy};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_ff <= DEV_RST;
    end else begin
      dev_ff <= nxt_dev;
    end
  end

  assign bus.dev_o  = dev_ff.o;
  assign bus.dev_oe = dev_ff.oe;
  assign wr_ok_o    = dev_ff.wr_ok;
  assign wr_rej_o   = dev_ff.wr_rej;
  assign fill_o     = dev_ff.fill;
  assign fill_val_o = dev_ff.fill_val;
  assign nv_bp_o    = dev_ff.bp;
  assign status_o   = dev_ff.status;
endmodule
`default_nettype wire

//--- ews_host.sv
/*
  Bus master end: wakes the device, then runs one command frame per
  write to its command register and reports through its own registers.
  Assumes a software port with read data one cycle after the strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module ews_host
  import ews_pkg::*;
#(
  parameter int STBY_CYC_P = STBY_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  ews_link_if.host        bus,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o
);
  ews_host_t  h_ff;
  ews_host_t  nxt_h;
  logic       saw;
  logic       hb;
  logic [2:0] np;

  always_comb begin
    nxt_h = h_ff;
    saw   = h_ff.rx_ok & h_ff.rx;
    np    = (h_ff.polls == 3'h0) ? 3'h1 : h_ff.polls;
    nxt_h.s1    = bus.line;
    nxt_h.s2    = h_ff.s1;
    nxt_h.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        HR_CMD:  nxt_h.rdata = h_ff.op;
        HR_DATA: nxt_h.rdata = h_ff.wdat;
        HR_CTRL: nxt_h.rdata = {4'h0, h_ff.bad, h_ff.polls};
        HR_STAT: nxt_h.rdata = {4'h0, h_ff.st == H_RDY, h_ff.done,
                                h_ff.sak_ok, h_ff.st != H_RDY};
        HR_RXST: nxt_h.rdata = h_ff.rxstat;
        default: nxt_h.rdata = 8'h00;
      endcase
    end
    if (wr_i && addr_i == HR_DATA) begin
      nxt_h.wdat = wdata_i;
    end
    if (wr_i && addr_i == HR_CTRL) begin
      nxt_h.polls = wdata_i[2:0];
      nxt_h.bad   = wdata_i[3];
    end
    unique case (h_ff.st)
      H_PWR: begin
        // Low then release gives the wake-up rise [RULE20]
        nxt_h.cnt = h_ff.cnt + 32'h1;
        if (h_ff.cnt == 32'(BIT_CYC - 1)) begin
          nxt_h.st  = H_STBY;
          nxt_h.cnt = '0;
        end
      end
      H_STBY: begin
        // One extra bit covers the device's sampling lag [RULE20]
        nxt_h.cnt = h_ff.cnt + 32'h1;
        if (h_ff.cnt == 32'(STBY_CYC_P + BIT_CYC)) begin
          nxt_h.st = H_RDY;
        end
      end
      H_RDY: begin
        if (wr_i && addr_i == HR_CMD) begin
          nxt_h.op     = wdata_i;
          nxt_h.st     = H_HDR;
          nxt_h.ph     = '0;
          nxt_h.bit_i  = '0;
          nxt_h.byte_i = '0;
          nxt_h.sh     = DEV_ADDR;
          nxt_h.sak_ok = 1'b1;
          nxt_h.done   = 1'b0;
          if (wdata_i == OP_RD_STAT) begin
            nxt_h.last = {1'b0, np} + 4'h1;
          end else if (wdata_i == OP_WR_STAT) begin
            nxt_h.last = 4'h2;
          end else begin
            nxt_h.last = 4'h1;
          end
        end
      end
      H_HDR: begin
        nxt_h.ph = h_ff.ph + 8'h1;
        if (h_ff.ph == PH_LAST) begin
          nxt_h.ph = '0;
          nxt_h.st = H_RUN;
        end
      end
      H_RUN: begin
        nxt_h.ph = h_ff.ph + 8'h1;
        if (h_ff.ph == PH_Q1) begin
          nxt_h.smp_a = h_ff.s2;
        end
        if (h_ff.ph == PH_Q3) begin
          nxt_h.rx    = h_ff.s2;
          nxt_h.rx_ok = h_ff.smp_a ^ h_ff.s2;
        end
        if (h_ff.ph == PH_LAST) begin
          nxt_h.ph    = '0;
          nxt_h.bit_i = h_ff.bit_i + 4'h1;
          if (h_ff.bit_i < SLOT_MAK) begin
            nxt_h.sh = {h_ff.sh[6:0], h_ff.rx};
          end else if (h_ff.bit_i == SLOT_SAK) begin
            if (!saw) begin
              nxt_h.sak_ok = 1'b0;
            end
            if (h_ff.op == OP_RD_STAT && h_ff.byte_i >= 4'd2) begin
              nxt_h.rxstat = h_ff.sh;
            end
            if (h_ff.byte_i == h_ff.last || !saw) begin
              nxt_h.st   = H_STBY;
              nxt_h.cnt  = '0;
              nxt_h.done = 1'b1;
            end else begin
              nxt_h.bit_i  = '0;
              nxt_h.byte_i = h_ff.byte_i + 4'h1;
              nxt_h.sh     = (h_ff.byte_i == 4'd0) ? h_ff.op : h_ff.wdat;
            end
          end
        end
      end
    endcase
    // Last byte takes no-acknowledge unless a bad end is asked for
    // [RULE2] [RULE10] [RULE11]
    hb = (nxt_h.bit_i == SLOT_MAK) ?
         ((nxt_h.byte_i != nxt_h.last) | nxt_h.bad) : nxt_h.sh[7];
    nxt_h.oe = (nxt_h.st == H_PWR) || (nxt_h.st == H_HDR) ||
               ((nxt_h.st == H_RUN) &&
                ((nxt_h.bit_i == SLOT_MAK) ||
                 ((nxt_h.bit_i < SLOT_MAK) &&
                  ((nxt_h.byte_i < 4'd2) ||
                   (nxt_h.op == OP_WR_STAT && nxt_h.byte_i == 4'd2)))));
    if (nxt_h.st == H_RUN) begin
      nxt_h.o = (nxt_h.ph < PH_HALF) ? ~hb : hb;
    end else begin
      nxt_h.o = (nxt_h.st == H_HDR) && (nxt_h.ph >= PH_HALF);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      h_ff <= HOST_RST;
    end else begin
      h_ff <= nxt_h;
    end
  end

  assign bus.host_o  = h_ff.o;
  assign bus.host_oe = h_ff.oe;
  assign rdata_o     = h_ff.rdata;
endmodule
`default_nettype wire

//--- ews_link_assertions.sv
/*
  Wire checker for the link between host and device ends.
  Assumes one clock, synchronous active-high reset, pulled-up line.
*/
`timescale 1ns/10ps
`default_nettype none
module ews_link_assertions #(
  parameter int STBY_P = 400
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic line
);
  logic [15:0] hi_cnt_ff;
  logic [15:0] drv_cnt_ff;
  logic        line_q_ff;
  logic        woke_ff;

  // Saturating run lengths; 16 bits cover any standby used here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_cnt_ff  <= 16'h0000;
      drv_cnt_ff <= 16'h0000;
      line_q_ff  <= 1'b1;
      woke_ff    <= 1'b0;
    end else begin
      hi_cnt_ff  <= !line ? 16'h0000 :
                    (&hi_cnt_ff) ? hi_cnt_ff : hi_cnt_ff + 16'h0001;
      drv_cnt_ff <= !dev_oe ? 16'h0000 :
                    (&drv_cnt_ff) ? drv_cnt_ff : drv_cnt_ff + 16'h0001;
      line_q_ff  <= line;
      woke_ff    <= woke_ff | (line & ~line_q_ff);
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Host starts a header only out of a long idle
  sequence s_hdr_start;
    $rose(host_oe) && hi_cnt_ff > 16'h00FA;
  endsequence
  // Device takes the line in the slot the host just gave up
  sequence s_sak_open;
    $rose(dev_oe) && $past(host_oe, 12);
  endsequence

  AST_WAKE_LOW: assert property (
      $fell(rst_i) |=> (host_oe && !host_o)[*8])
    else $error("host did not hold the line low after reset");
  AST_HDR_STBY: assert property (
      s_hdr_start |-> hi_cnt_ff >= 16'(STBY_P))
    else $error("header started without a full standby");
  AST_HDR_LOW: assert property (
      s_hdr_start |-> (!line)[*8])
    else $error("header does not open with a low level");
  AST_SHUT_QUIET: assert property (
      !woke_ff |-> !dev_oe)
    else $error("device drove the line before any rising edge");
  AST_SAK_FIRST_HALF: assert property (
      s_sak_open |-> (dev_oe && !dev_o)[*8])
    else $error("acknowledge slot does not open low");
  AST_SAK_MIDRISE: assert property (
      s_sak_open |-> ##[90:110] $rose(dev_o))
    else $error("acknowledge slot has no rise near mid-bit");
  AST_SAK_ENDS_HIGH: assert property (
      $fell(dev_oe) && drv_cnt_ff < 16'h00D2 |-> $past(dev_o))
    else $error("acknowledge slot released while low");
  AST_HOST_YIELDS: assert property (
      s_sak_open |-> (!host_oe)[*8])
    else $error("host drives during the acknowledge slot");
endmodule
`default_nettype wire

//--- eeprom_write_protect_status_tb.sv
/*
  Bench: host and device ends joined on one link; software port on the
  host, the bench plays the array owner on the device side.
  Assumes shortened standby and write-cycle counts.
*/
`timescale 1ns/10ps
`default_nettype none
module eeprom_write_protect_status_tb;
  import ews_pkg::*;
  localparam int STBY_P = 400;
  // Long enough to span two command frames
  localparam int TWC_P  = 10000;
  logic              clk_i     = 1'b0;
  logic              rst_i     = 1'b1;
  logic [2:0]        addr_i    = 3'h0;
  logic [7:0]        wdata_i   = 8'h00;
  logic              wr_i      = 1'b0;
  logic              rd_i      = 1'b0;
  logic              wr_req_i  = 1'b0;
  logic [ARR_AW-1:0] wr_addr_i = 7'h00;
  logic [1:0]        nv_bp_i   = 2'h0;
  logic [7:0]        rdata_o, fill_val_o, status_o, s;
  logic [1:0]        nv_bp_o;
  logic              wr_ok_o, wr_rej_o, fill_o;
  int                n_fail = 0, tests_run = 0;
  int                n_ok = 0, n_rej = 0, n_fill = 0;

  ews_link_if lnk ();
  ews_host #(.STBY_CYC_P(STBY_P)) i_ews_host (
    .clk_i(clk_i), .rst_i(rst_i), .bus(lnk.host), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  ews_dev #(.STBY_CYC_P(STBY_P), .TWC_CYC_P(TWC_P)) i_ews_dev (
    .clk_i(clk_i), .rst_i(rst_i), .bus(lnk.dev), .nv_bp_i(nv_bp_i),
    .wr_req_i(wr_req_i), .wr_addr_i(wr_addr_i), .wr_ok_o(wr_ok_o),
    .wr_rej_o(wr_rej_o), .fill_o(fill_o), .fill_val_o(fill_val_o),
    .nv_bp_o(nv_bp_o), .status_o(status_o));
  ews_link_assertions #(.STBY_P(STBY_P)) i_ews_link_assertions (
    .clk_i(clk_i), .rst_i(rst_i), .host_o(lnk.host_o),
    .host_oe(lnk.host_oe), .dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe),
    .line(lnk.line));

  always #25 clk_i = ~clk_i;

  // Pulses are counted so checks need not hit their exact cycle
  always @(posedge clk_i) begin
    if (wr_ok_o === 1'b1) n_ok++;
    if (wr_rej_o === 1'b1) n_rej++;
    if (fill_o === 1'b1) n_fill++;
  end

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic need(input logic ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask

  // Idle cycle after each strobe keeps one assignment per time step
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_i);
  endtask

  // One frame: wait ready, start, wait done; s keeps the last status
  task automatic run_cmd(input logic [7:0] op, input logic [7:0] dat,
                         input logic [7:0] ctl);
    int i;
    reg_wr(HR_DATA, dat);
    reg_wr(HR_CTRL, ctl);
    s = 8'h00;
    for (i = 0; i < 4000 && s[3] !== 1'b1; i++) reg_rd(HR_STAT, s);
    need(s[3]);
    reg_wr(HR_CMD, op);
    s = 8'h00;
    for (i = 0; i < 10000 && s[2] !== 1'b1; i++) reg_rd(HR_STAT, s);
    need(s[2]);
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 30000 && status_o[0] !== 1'b0; i++) @(posedge clk_i);
    need(~status_o[0]);
  endtask

  task automatic arr_wr(input logic [ARR_AW-1:0] a);
    wr_addr_i <= a;
    wr_req_i  <= 1'b1;
    @(posedge clk_i);
    wr_req_i  <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(status_o, 8'h00);
    chk({6'h00, nv_bp_o}, 8'h00);
    reg_rd(HR_STAT, s);
    chk(s, 8'h01);
    $display("test reset done");
    run_cmd(OP_SET_LATCH, 8'h00, 8'h00);
    chk(s & 8'h02, 8'h02);
    chk(status_o, 8'h02);
    arr_wr(7'h7F);
    chk(n_ok[7:0], 8'h01);
    chk(status_o, 8'h01);
    run_cmd(OP_SET_LATCH, 8'h00, 8'h00);
    run_cmd(OP_FILL0, 8'h00, 8'h00);
    chk(n_fill[7:0], 8'h00);
    wait_idle();
    chk(status_o, 8'h02);
    $display("test busy done");
    run_cmd(OP_FILL0, 8'h00, 8'h00);
    chk(n_fill[7:0], 8'h01);
    chk(fill_val_o, FILL0_VAL);
    chk(status_o, 8'h01);
    wait_idle();
    run_cmd(OP_SET_LATCH, 8'h00, 8'h00);
    run_cmd(OP_FILL1, 8'h00, 8'h00);
    chk(n_fill[7:0], 8'h02);
    chk(fill_val_o, FILL1_VAL);
    $display("test fill done");
    run_cmd(OP_SET_LATCH, 8'h00, 8'h08);
    chk(s & 8'h02, 8'h00);
    chk(status_o & 8'h02, 8'h00);
    arr_wr(7'h00);
    chk(n_rej[7:0], 8'h01);
    run_cmd(OP_SET_LATCH, 8'h00, 8'h00);
    run_cmd(OP_CLR_LATCH, 8'h00, 8'h00);
    chk(status_o & 8'h02, 8'h00);
    wait_idle();
    $display("test latch done");
    run_cmd(OP_SET_LATCH, 8'h00, 8'h00);
    run_cmd(OP_WR_STAT, 8'h08, 8'h08);
    chk({6'h00, nv_bp_o}, 8'h00);
    run_cmd(OP_WR_STAT, 8'h08, 8'h00);
    chk({6'h00, nv_bp_o}, 8'h02);
    chk(status_o, 8'h09);
    run_cmd(OP_RD_STAT, 8'h00, 8'h02);
    reg_rd(HR_RXST, s);
    chk(s, 8'h09);
    wait_idle();
    run_cmd(OP_SET_LATCH, 8'h00, 8'h00);
    run_cmd(OP_FILL0, 8'h00, 8'h00);
    chk(n_fill[7:0], 8'h02);
    arr_wr(7'h40);
    chk(n_rej[7:0], 8'h02);
    arr_wr(7'h3F);
    chk(n_ok[7:0], 8'h02);
    $display("test protect done");
    // Restart with the stored protect bits fed back
    nv_bp_i <= nv_bp_o;
    rst_i   <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i   <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({6'h00, nv_bp_o}, 8'h02);
    chk(status_o, 8'h08);
    $display("test restart done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
